/* File: rtl/qpd_pkg.sv */
// Constants shared by the quad pot command decoder
package qpd_pkg;
   localparam int          NPOT        = 4;
   localparam int          NSET        = 4;
   localparam int          TAP_W       = 6;
   localparam logic [5:0]  TAP_MAX     = 6'h3F;
   localparam logic [5:0]  TAP_MIN     = 6'h00;
   localparam logic [5:0]  NV_RESET    = 6'h00;
   localparam logic [3:0]  BYTE_BITS   = 4'h8;
   localparam logic [1:0]  SET_ZERO    = 2'h0;
   // Instruction opcodes, upper nibble of the instruction byte
   localparam logic [3:0]  OP_RD_WIP   = 4'h9;
   localparam logic [3:0]  OP_WR_WIP   = 4'hA;
   localparam logic [3:0]  OP_RD_SET   = 4'hB;
   localparam logic [3:0]  OP_WR_SET   = 4'hC;
   localparam logic [3:0]  OP_S2W      = 4'hD;
   localparam logic [3:0]  OP_W2S      = 4'hE;
   localparam logic [3:0]  OP_GANG_S2W = 4'h1;
   localparam logic [3:0]  OP_GANG_W2S = 4'h8;
   localparam logic [3:0]  OP_STEP     = 4'h2;
   // Non-volatile programming time and the clock rate
   localparam int          NV_WRITE_MS = 5;
   localparam int          MCLK_HZ     = 10_000_000;

   typedef enum logic [3:0] {
      QPD_IDLE  = 4'h0,
      QPD_ADDR  = 4'h1,
      QPD_ACK_A = 4'h3,
      QPD_INSTR = 4'h2,
      QPD_ACK_I = 4'h6,
      QPD_WDATA = 4'h7,
      QPD_ACK_D = 4'h5,
      QPD_WAIT  = 4'h4,
      QPD_RDATA = 4'hC,
      QPD_RACK  = 4'hD,
      QPD_STEP  = 4'hF
   } qpd_state_t;
endpackage : qpd_pkg

/* File: rtl/qpd_line_if.sv */
// Sampled bus line events passed from the line sensor to the decoder
`timescale 1ns/100ps
`default_nettype none
interface qpd_line_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic start_det;
   logic stop_det;

   modport sense (output scl_rise, scl_fall, sda_lvl, start_det, stop_det);
   modport core  (input  scl_rise, scl_fall, sda_lvl, start_det, stop_det);
endinterface : qpd_line_if
`default_nettype wire

/* File: rtl/qpd_bus_sense.sv */
// Two-wire line synchroniser with edge, START and STOP detection
`timescale 1ns/100ps
`default_nettype none
module qpd_bus_sense
(
   input  wire logic  mclk,
   input  wire logic  rst,
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   qpd_line_if.sense  ln
);
   logic [2:0] scl_q;
   logic [2:0] sda_q;

   // Stage 0 feeds stage 1 only; stages 1 and 2 feed the detectors
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end
      else
      begin
         scl_q <= {scl_q[1:0], scl_in};
         sda_q <= {sda_q[1:0], sda_in};
      end
   end

   // Events last one mclk cycle each
   assign ln.scl_rise  = scl_q[1] & ~scl_q[2];
   assign ln.scl_fall  = ~scl_q[1] & scl_q[2];
   assign ln.sda_lvl   = sda_q[1];
   // SDA moving while SCL stays high marks frame boundaries
   assign ln.start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   assign ln.stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
endmodule : qpd_bus_sense
`default_nettype wire

/* File: rtl/qpd_decoder.sv */
// Quad pot serial command decoder with wiper and stored-setting registers
`timescale 1ns/100ps
`default_nettype none
module qpd_decoder
   import qpd_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE        = 4'hA, // Arbitrary type code
   parameter int         NV_WRITE_CYCLES = NV_WRITE_MS * (MCLK_HZ / 1000)
)
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic        addr_strap_3,
   input  wire logic        addr_strap_2,
   input  wire logic        addr_strap_1,
   input  wire logic        addr_strap_0,
   output logic             sda_out,
   output logic             sda_oe_n,
   output logic             nv_busy,
   output logic [23:0]      wiper_taps
);
   localparam int BW = $clog2(NV_WRITE_CYCLES + 1);

   qpd_line_if              ln ();
   qpd_state_t              state_q;
   logic [3:0]              cnt_q;
   logic [7:0]              sh_q;
   logic [3:0]              op_q;
   logic [1:0]              sel_q;
   logic [1:0]              pot_q;
   logic                    oe_n_q;
   logic                    dir_q;
   logic                    pend_q;
   logic                    init_q;
   logic [3:0]              strap_s0_q;
   logic [3:0]              strap_s1_q;
   logic [BW-1:0]           busy_cnt_q;
   logic [TAP_W-1:0]        wip_q [NPOT];
   logic [TAP_W-1:0]        nv_q  [NPOT][NSET];
   logic                    byte_fall;
   logic                    op_ok;
   logic                    busy;
   logic                    instr_done;
   logic                    wdata_done;
   logic                    step_pulse;
   logic                    commit;
   logic [7:0]              rd_byte;

   qpd_bus_sense u_sense
   (
      .mclk   (mclk),
      .rst    (rst),
      .scl_in (scl_in),
      .sda_in (sda_in),
      .ln     (ln.sense)
   );

   // Strap pins are asynchronous levels, so two flops first
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         strap_s0_q <= 4'h0;
         strap_s1_q <= 4'h0;
      end
      else
      begin
         strap_s0_q <= {addr_strap_3, addr_strap_2, addr_strap_1,
                        addr_strap_0};
         strap_s1_q <= strap_s0_q;
      end
   end

   // Opcode check; pot bits must be zero for gang, setting bits for wiper ops
   always_comb
   begin
      case (sh_q[7:4])
         OP_RD_WIP,
         OP_WR_WIP,
         OP_STEP:     op_ok = (sh_q[3:2] == 2'h0);
         OP_GANG_S2W,
         OP_GANG_W2S: op_ok = (sh_q[1:0] == 2'h0);
         OP_RD_SET,
         OP_WR_SET,
         OP_S2W,
         OP_W2S:      op_ok = 1'b1;
         default:     op_ok = 1'b0;
      endcase
   end

   // Strobes from the sequencer to the register concerns
   assign busy       = (busy_cnt_q != '0);
   assign byte_fall  = ln.scl_fall && (cnt_q == BYTE_BITS);
   assign instr_done = (state_q == QPD_INSTR) && byte_fall && op_ok &&
                       !ln.start_det && !ln.stop_det;
   assign wdata_done = (state_q == QPD_WDATA) && byte_fall &&
                       !ln.start_det && !ln.stop_det;
   assign step_pulse = (state_q == QPD_STEP) && ln.scl_fall &&
                       !ln.start_det;
   assign commit     = ln.stop_det && pend_q;
   // Upper two bits always zero on reads
   assign rd_byte    = (op_q == OP_RD_WIP) ? {2'b00, wip_q[pot_q]}
                       : {2'b00, nv_q[pot_q][sel_q]};

   // Frame sequencer: bits sampled on SCL rise, SDA changed on SCL fall
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= QPD_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         op_q    <= 4'h0;
         sel_q   <= 2'h0;
         pot_q   <= 2'h0;
         oe_n_q  <= 1'b1;
         dir_q   <= 1'b0;
      end
      else if (ln.start_det)
      begin
         state_q <= QPD_ADDR;
         cnt_q   <= 4'h0;
         oe_n_q  <= 1'b1;
      end
      else if (ln.stop_det)
      begin
         state_q <= QPD_IDLE;
         oe_n_q  <= 1'b1;
      end
      else
      begin
         case (state_q)
            QPD_ADDR,
            QPD_INSTR,
            QPD_WDATA:
            begin
               if (ln.scl_rise)
               begin
                  sh_q  <= {sh_q[6:0], ln.sda_lvl};
                  cnt_q <= cnt_q + 4'h1;
               end
               else if (byte_fall)
               begin
                  cnt_q <= 4'h0;
                  if (state_q == QPD_ADDR)
                  begin
                     // Wrong type, wrong strap or busy: stay silent
                     if (sh_q == {DEV_TYPE, strap_s1_q} && !busy)
                     begin
                        state_q <= QPD_ACK_A;
                        oe_n_q  <= 1'b0;
                     end
                     else
                        state_q <= QPD_WAIT;
                  end
                  else if (state_q == QPD_INSTR)
                  begin
                     op_q  <= sh_q[7:4];
                     sel_q <= sh_q[3:2];
                     pot_q <= sh_q[1:0];
                     state_q <= op_ok ? QPD_ACK_I : QPD_WAIT;
                     oe_n_q  <= !op_ok;
                  end
                  else
                  begin
                     state_q <= QPD_ACK_D;
                     oe_n_q  <= 1'b0;
                  end
               end
            end
            QPD_ACK_A:
            begin
               if (ln.scl_fall)
               begin
                  state_q <= QPD_INSTR;
                  oe_n_q  <= 1'b1;
               end
            end
            QPD_ACK_I:
            begin
               if (ln.scl_fall)
               begin
                  case (op_q)
                     OP_RD_WIP,
                     OP_RD_SET:
                     begin
                        state_q <= QPD_RDATA;
                        sh_q    <= rd_byte;
                        oe_n_q  <= rd_byte[7];
                        cnt_q   <= 4'h1;
                     end
                     OP_WR_WIP,
                     OP_WR_SET:
                     begin
                        state_q <= QPD_WDATA;
                        oe_n_q  <= 1'b1;
                     end
                     OP_STEP:
                     begin
                        state_q <= QPD_STEP;
                        oe_n_q  <= 1'b1;
                     end
                     default:
                     begin
                        state_q <= QPD_WAIT;
                        oe_n_q  <= 1'b1;
                     end
                  endcase
               end
            end
            QPD_RDATA:
            begin
               if (ln.scl_fall)
               begin
                  if (cnt_q == BYTE_BITS)
                  begin
                     state_q <= QPD_RACK;
                     oe_n_q  <= 1'b1;
                  end
                  else
                  begin
                     // Released line reads as one, driven line as zero
                     oe_n_q <= sh_q[6];
                     sh_q   <= {sh_q[6:0], 1'b0};
                     cnt_q  <= cnt_q + 4'h1;
                  end
               end
            end
            QPD_RACK:
            begin
               if (ln.scl_fall)
                  state_q <= QPD_WAIT;
            end
            QPD_ACK_D:
            begin
               if (ln.scl_fall)
               begin
                  state_q <= QPD_WAIT;
                  oe_n_q  <= 1'b1;
               end
            end
            QPD_STEP:
            begin
               // Direction caught at rise, applied when the pulse ends
               if (ln.scl_rise)
                  dir_q <= ln.sda_lvl;
            end
            default:
               state_q <= state_q;
         endcase
      end
   end

   // Pending programming request, raised by accepted stores
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         pend_q <= 1'b0;
      else if (ln.stop_det)
         pend_q <= 1'b0;
      else if (ln.start_det)
         pend_q <= 1'b0;
      else if ((instr_done && (sh_q[7:4] == OP_W2S ||
                               sh_q[7:4] == OP_GANG_W2S)) ||
               (wdata_done && op_q == OP_WR_SET))
         pend_q <= 1'b1;
   end

   // Stored settings change only at STOP
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NPOT; i++)
            for (int j = 0; j < NSET; j++)
               nv_q[i][j] <= NV_RESET;
      end
      else if (commit)
      begin
         case (op_q)
            OP_WR_SET: nv_q[pot_q][sel_q] <= sh_q[5:0];
            OP_W2S:    nv_q[pot_q][sel_q] <= wip_q[pot_q];
            default:
               for (int i = 0; i < NPOT; i++)
                  nv_q[i][sel_q] <= wip_q[i];
         endcase
      end
   end

   // Programming timer; whole device refuses frames while it runs
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         busy_cnt_q <= '0;
      else if (commit)
         busy_cnt_q <= BW'(NV_WRITE_CYCLES);
      else if (busy)
         busy_cnt_q <= busy_cnt_q - 1'b1;
   end

   // Wiper registers: power-up load, writes, loads and stepping
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         init_q <= 1'b0;
         for (int i = 0; i < NPOT; i++)
            wip_q[i] <= NV_RESET;
      end
      else if (!init_q)
      begin
         init_q <= 1'b1;
         for (int i = 0; i < NPOT; i++)
            wip_q[i] <= nv_q[i][SET_ZERO];
      end
      else if (instr_done && sh_q[7:4] == OP_S2W)
         wip_q[sh_q[1:0]] <= nv_q[sh_q[1:0]][sh_q[3:2]];
      else if (instr_done && sh_q[7:4] == OP_GANG_S2W)
      begin
         for (int i = 0; i < NPOT; i++)
            wip_q[i] <= nv_q[i][sh_q[3:2]];
      end
      else if (wdata_done && op_q == OP_WR_WIP)
         wip_q[pot_q] <= sh_q[5:0];
      else if (step_pulse)
      begin
         // Saturate at both ends rather than wrap
         if (dir_q && wip_q[pot_q] != TAP_MAX)
            wip_q[pot_q] <= wip_q[pot_q] + 6'h01;
         else if (!dir_q && wip_q[pot_q] != TAP_MIN)
            wip_q[pot_q] <= wip_q[pot_q] - 6'h01;
      end
   end

   // Open-drain data line: only ever pulled low
   assign sda_out    = 1'b0;
   assign sda_oe_n   = oe_n_q;
   assign nv_busy    = busy;
   assign wiper_taps = {wip_q[3], wip_q[2], wip_q[1], wip_q[0]};
endmodule : qpd_decoder
`default_nettype wire

/* File: tb/qpd_decoder_props.sv */
// Pin-level checker for the quad pot command decoder
`timescale 1ns/100ps
`default_nettype none
module qpd_decoder_props
#(
   parameter int NV_WRITE_CYCLES = 50000
)
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        addr_strap_3,
   input wire logic        addr_strap_2,
   input wire logic        addr_strap_1,
   input wire logic        addr_strap_0,
   input wire logic        sda_out,
   input wire logic        sda_oe_n,
   input wire logic        nv_busy,
   input wire logic [23:0] wiper_taps
);
   logic [31:0] busy_cnt_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Length of the running programming cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         busy_cnt_q <= '0;
      else
         busy_cnt_q <= nv_busy ? busy_cnt_q + 32'd1 : '0;
   end

   // A driven bit lasts close to a whole link period
   sequence s_low_run;
      !sda_oe_n [*6];
   endsequence
   sequence s_high_run;
      sda_oe_n [*6];
   endsequence

   property p_od_value;
      !sda_oe_n |-> !sda_out;
   endproperty
   property p_ack_low;
      $fell(sda_oe_n) |-> s_low_run;
   endproperty
   property p_release_high;
      $rose(sda_oe_n) |-> s_high_run;
   endproperty
   property p_drive_scl_low;
      $changed(sda_oe_n) |-> !scl_in;
   endproperty
   property p_wiper_scl_low;
      $changed(wiper_taps) |-> !scl_in;
   endproperty
   property p_busy_after_stop;
      $rose(nv_busy) |-> scl_in && sda_in;
   endproperty
   property p_busy_len;
      $fell(nv_busy) |-> busy_cnt_q == NV_WRITE_CYCLES;
   endproperty
   property p_busy_no_ack;
      nv_busy |-> sda_oe_n;
   endproperty

   a_od_value: assert property (p_od_value)
      else $error("data pin driven high");
   a_ack_low: assert property (p_ack_low)
      else $error("driven low bit too short");
   a_release_high: assert property (p_release_high)
      else $error("released bit too short");
   a_drive_scl_low: assert property (p_drive_scl_low)
      else $error("data drive changed with clock high");
   a_wiper_scl_low: assert property (p_wiper_scl_low)
      else $error("wiper changed with clock high");
   a_busy_after_stop: assert property (p_busy_after_stop)
      else $error("programming began before stop");
   a_busy_len: assert property (p_busy_len)
      else $error("programming length wrong");
   a_busy_no_ack: assert property (p_busy_no_ack)
      else $error("acknowledge while programming");
endmodule : qpd_decoder_props

bind qpd_decoder qpd_decoder_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_props
(
   .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .addr_strap_3(addr_strap_3), .addr_strap_2(addr_strap_2),
   .addr_strap_1(addr_strap_1), .addr_strap_0(addr_strap_0),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .nv_busy(nv_busy),
   .wiper_taps(wiper_taps)
);
`default_nettype wire

/* File: tb/qpd_bus_master.sv */
// Two-wire bus master model for the decoder bench
`timescale 1ns/100ps
`default_nettype none
module qpd_bus_master
(
   input  wire logic mclk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_m
);
   // Released lines idle high; clock stands still between frames
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task start();
      tick(3);
      sda_m = 1'b0;
      tick(3);
      scl = 1'b0;
   endtask : start

   // Data moves 3 cycles clear of clock edges for the synchroniser
   task bit_x(input logic b, output logic r);
      tick(3);
      sda_m = b;
      tick(3);
      scl = 1'b1;
      tick(1);
      r = sda;
      tick(1);
      scl = 1'b0;
   endtask : bit_x

   // Byte out MSB first, then sample the acknowledge
   task wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask : wbyte

   // Byte in MSB first; closing acknowledge is left high
   task rbyte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(1'b1, r);
   endtask : rbyte

   // Every frame ends here, also step runs
   task stop();
      tick(3);
      sda_m = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(3);
      sda_m = 1'b1;
      tick(3);
   endtask : stop
endmodule : qpd_bus_master
`default_nettype wire

/* File: tb/tb_qpd_decoder.sv */
// Self-checking bench for the quad pot command decoder
`timescale 1ns/100ps
`default_nettype none
module tb_qpd_decoder;
   import qpd_pkg::*;
   localparam int         NVW       = 200;
   localparam int         LIMIT     = 40000;
   localparam logic [3:0] TYPE_CODE = 4'hA; // Arbitrary type code
   localparam logic [3:0] STRAPS    = 4'h6;
   localparam logic [7:0] ADDR      = {TYPE_CODE, STRAPS};
   logic        mclk;
   logic        rst;
   logic        scl;
   logic        sda_m;
   logic        sda_wire;
   logic        sda_out;
   logic        sda_oe_n;
   logic        nv_busy;
   logic [3:0]  straps;
   logic [23:0] wiper_taps;
   int          errors;
   int          checks;
   int          cyc;

   // Open-drain wire: pulled up unless someone pulls low
   assign sda_wire = sda_m & (sda_oe_n | sda_out);

   qpd_decoder #(.DEV_TYPE(TYPE_CODE), .NV_WRITE_CYCLES(NVW)) DUT
   (
      .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
      .addr_strap_3(straps[3]), .addr_strap_2(straps[2]),
      .addr_strap_1(straps[1]), .addr_strap_0(straps[0]),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .nv_busy(nv_busy),
      .wiper_taps(wiper_taps)
   );
   qpd_bus_master m (.mclk(mclk), .sda(sda_wire), .scl(scl), .sda_m(sda_m));

   initial
   begin
      mclk = 1'b0;
   end
   always #50 mclk = ~mclk;

   // Hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         errors++;
         final_report();
      end
   end

   task final_report();
      if (errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   function automatic logic [7:0] wip(input int p);
      return {2'b00, wiper_taps[p*6 +: 6]};
   endfunction : wip

   task send(input logic [7:0] b, input logic e);
      logic a;
      m.wbyte(b, a);
      cmp({7'h0, a}, {7'h0, e});
   endtask : send

   // Programming time is fixed, so a fixed wait with a 10-cycle margin covers it
   task idle();
      repeat (NVW + 10) @(posedge mclk);
      #1;
      cmp({7'h0, nv_busy}, 8'h00);
   endtask : idle

   task wr(input logic [7:0] ins, input logic [7:0] d);
      m.start();
      send(ADDR, 1'b1);
      send(ins, 1'b1);
      send(d, 1'b1);
      m.stop();
      idle();
   endtask : wr

   task xf(input logic [7:0] ins);
      m.start();
      send(ADDR, 1'b1);
      send(ins, 1'b1);
      m.stop();
      idle();
   endtask : xf

   task rd(input logic [7:0] ins, input logic [7:0] exp);
      logic [7:0] r;
      m.start();
      send(ADDR, 1'b1);
      send(ins, 1'b1);
      m.rbyte(r);
      m.stop();
      cmp(r, exp);
   endtask : rd

   task sc_wiper();
      wr({OP_WR_WIP, 4'h2}, 8'hFF);
      cmp(wip(2), 8'h3F);
      rd({OP_RD_WIP, 4'h2}, 8'h3F);
   endtask : sc_wiper

   // Two ups at the top end, three downs, one up
   task sc_step();
      logic r;
      logic [5:0] dirs;
      dirs = 6'b110001;
      m.start();
      send(ADDR, 1'b1);
      send({OP_STEP, 4'h2}, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         m.bit_x(dirs[5-i], r);
         if (i == 1)
         begin
            m.tick(4);
            cmp(wip(2), 8'h3F);
         end
      end
      m.stop();
      cmp(wip(2), 8'h3D);
   endtask : sc_step

   task sc_setting();
      m.start();
      send(ADDR, 1'b1);
      send({OP_WR_SET, 2'd2, 2'd1}, 1'b1);
      send(8'hD5, 1'b1);
      cmp({7'h0, nv_busy}, 8'h00);
      m.stop();
      m.tick(3);
      cmp({7'h0, nv_busy}, 8'h01);
      m.start();
      send(ADDR, 1'b0);
      m.stop();
      idle();
      rd({OP_RD_SET, 2'd2, 2'd1}, 8'h15);
      xf({OP_S2W, 2'd2, 2'd1});
      cmp(wip(1), 8'h15);
      xf({OP_W2S, 2'd3, 2'd2});
      rd({OP_RD_SET, 2'd3, 2'd2}, 8'h3D);
   endtask : sc_setting

   task sc_gang();
      for (int p = 0; p < 4; p++)
         wr({OP_WR_WIP, 2'd0, p[1:0]}, 8'(8'h11 * (p + 1)));
      xf({OP_GANG_W2S, 2'd1, 2'd0});
      for (int p = 0; p < 4; p++)
         wr({OP_WR_WIP, 2'd0, p[1:0]}, 8'h00);
      xf({OP_GANG_S2W, 2'd1, 2'd0});
      for (int p = 0; p < 4; p++)
         cmp(wip(p), 8'(8'h11 * (p + 1)) & 8'h3F);
   endtask : sc_gang

   // Other strap address: frame is ignored entirely
   task sc_addr();
      m.start();
      send({TYPE_CODE, ~STRAPS}, 1'b0);
      send({OP_WR_WIP, 4'h0}, 1'b0);
      send(8'h2A, 1'b0);
      m.stop();
      cmp(wip(0), 8'h11);
      // Malformed instructions: setting bits on a wiper read, pot bits on gang
      m.start();
      send(ADDR, 1'b1);
      send({OP_RD_WIP, 4'h4}, 1'b0);
      m.stop();
      m.start();
      send(ADDR, 1'b1);
      send({OP_GANG_S2W, 4'h1}, 1'b0);
      m.stop();
      cmp(wip(0), 8'h11);
   endtask : sc_addr

   initial
   begin
      errors = 0;
      checks = 0;
      cyc = 0;
      rst = 1'b1;
      straps = STRAPS;
      repeat (5) @(posedge mclk);
      #1;
      rst = 1'b0;
      m.tick(5);
      for (int p = 0; p < 4; p++)
         cmp(wip(p), 8'h00);
      sc_wiper();
      sc_step();
      sc_setting();
      sc_gang();
      sc_addr();
      final_report();
   end
endmodule : tb_qpd_decoder
`default_nettype wire
